// file: dba_pkg.sv
/*
 * Shared types and constants for the data bus arbiter.
 * Assumes a single 10 MHz system clock; all counts are derived from it.
 */
package dba_pkg;

    // ----------------------------------------------------------------
    // Levels and timing
    // ----------------------------------------------------------------
    localparam int DBA_LEVELS = 4;
    localparam logic [1:0] DBA_TOP_LEVEL = 2'h3;
    localparam int DBA_CLK_NS = 100;
    // Withdraw an unanswered grant after this time; a least time, so round up
    localparam int DBA_TIMEOUT_NS = 20000;
    localparam int DBA_TIMEOUT_CYC = (DBA_TIMEOUT_NS + DBA_CLK_NS - 1) / DBA_CLK_NS;
    localparam int DBA_TMR_W = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] DBA_GRANT_RST = 4'hf;
    localparam logic [3:0] DBA_REQ_RST = 4'hf;
    localparam logic [1:0] DBA_LAST_RST = 2'h0;
    localparam logic [DBA_TMR_W-1:0] DBA_TMR_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DBA_ST_IDLE = 2'h0,
        DBA_ST_OFFER = 2'h1,
        DBA_ST_HELD = 2'h3
    } dba_state_t;

    typedef enum logic [1:0] {
        DBA_MODE_PRI = 2'h0,
        DBA_MODE_RRS = 2'h1,
        DBA_MODE_SGL = 2'h2,
        DBA_MODE_MIX = 2'h3
    } dba_mode_t;

    // ----------------------------------------------------------------
    // Module state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] req_meta_n;
        logic [3:0] req_sync_n;
        logic busy_meta_n;
        logic busy_sync_n;
        dba_state_t state;
        logic [3:0] grant_n;
        logic clear_n;
        logic [1:0] last_lvl;
        logic [DBA_TMR_W-1:0] timer;
    } dba_regs_t;

endpackage

// file: dba_arbiter.sv
/*
 * Slot-one arbiter for the shared data transfer bus: samples the four
 * request levels and bus busy, issues one grant onto the daisy chains,
 * and raises bus clear when another request waits (prioritized: only a higher one; single-level: never).
 * Assumes requesters pass unused grant levels downstream and answer a
 * grant by pulling bus busy low; the bus inputs are active low and async.
 */
//
// Functional notes
// - Only one board owns the bus at any time; one grant at once.
// - Arbitration bus has six bused lines and four grant chains.
// - Request and grant levels are numbered zero through three.
// - Grant out of slot n feeds grant in of slot n plus one.
// - Prioritized mode: fixed priority, level three highest, zero lowest.
// - Round-robin: after granting n, level n minus one ranks highest next.
// - Single-level mode accepts only level three; chain picks the board.
// - Other schemes allowed: level three fixed, round-robin over zero to two.
// - Busy high with requests pending: grant the level the scheme picks.
// - No new grant before busy rises again, except after a timeout.
`timescale 1ns/1ps

module dba_arbiter #(
    parameter int TIMEOUT_CYC = dba_pkg::DBA_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] bus_req_n,
    input wire logic bus_busy_n,
    input wire dba_pkg::dba_mode_t arb_mode,
    output logic [3:0] bus_grant_n,
    output logic bus_clear_n
);

    localparam logic [dba_pkg::DBA_TMR_W-1:0] TMR_LAST = dba_pkg::DBA_TMR_W'(TIMEOUT_CYC - 1);

    // ----------------------------------------------------------------
    // Level selection
    // ----------------------------------------------------------------
    // Scan downward from start, wrapping; returns {found, level}
    function automatic logic [2:0] dba_pick(input logic [3:0] req, input logic [1:0] start);
        logic [2:0] res;
        logic [1:0] lvl;
        res = 3'h0;
        lvl = start;
        for (int i = 0; i < dba_pkg::DBA_LEVELS; i++) begin
            if (!res[2] && req[lvl]) begin
                res = {1'b1, lvl};
            end
            lvl = lvl - 2'h1;
        end
        return res;
    endfunction

    dba_pkg::dba_regs_t st_r;
    dba_pkg::dba_regs_t st_nxt;
    logic [3:0] req_act;
    logic [2:0] choice;
    logic [1:0] mix_start;

    assign req_act = ~st_r.req_sync_n;

    always_comb begin
        // Rotation start within levels zero to two for the mixed scheme
        mix_start = (st_r.last_lvl == 2'h0 || st_r.last_lvl == 2'h3) ? 2'h2 : st_r.last_lvl - 2'h1;
        unique case (arb_mode)
            dba_pkg::DBA_MODE_PRI: begin
                choice = dba_pick(req_act, dba_pkg::DBA_TOP_LEVEL);
            end
            dba_pkg::DBA_MODE_RRS: begin
                choice = dba_pick(req_act, st_r.last_lvl - 2'h1);
            end
            dba_pkg::DBA_MODE_SGL: begin
                choice = {req_act[3], dba_pkg::DBA_TOP_LEVEL};
            end
            dba_pkg::DBA_MODE_MIX: begin
                // Level three first, then a rotation that never includes it
                if (req_act[3]) begin
                    choice = {1'b1, dba_pkg::DBA_TOP_LEVEL};
                end else begin
                    choice = dba_pick({1'b0, req_act[2:0]}, mix_start);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Two-stage synchronisers; only the second stage is looked at
        st_nxt.req_meta_n = bus_req_n;
        st_nxt.req_sync_n = st_r.req_meta_n;
        st_nxt.busy_meta_n = bus_busy_n;
        st_nxt.busy_sync_n = st_r.busy_meta_n;
        st_nxt.clear_n = 1'b1;
        unique case (st_r.state)
            dba_pkg::DBA_ST_IDLE: begin
                st_nxt.timer = dba_pkg::DBA_TMR_RST;
                // Decide on live request levels once the bus is free
                if (st_r.busy_sync_n && choice[2]) begin
                    st_nxt.state = dba_pkg::DBA_ST_OFFER;
                    // Drive exactly one slot-one grant line onto its chain
                    st_nxt.grant_n = ~(4'h1 << choice[1:0]);
                    st_nxt.last_lvl = choice[1:0];
                end
            end
            dba_pkg::DBA_ST_OFFER: begin
                st_nxt.timer = st_r.timer + 16'h0001;
                if (!st_r.busy_sync_n) begin
                    // Owner has taken the bus; grant can drop
                    st_nxt.state = dba_pkg::DBA_ST_HELD;
                    st_nxt.grant_n = dba_pkg::DBA_GRANT_RST;
                end else if (st_r.timer == TMR_LAST) begin
                    // Nobody answered: withdraw and arbitrate afresh
                    st_nxt.state = dba_pkg::DBA_ST_IDLE;
                    st_nxt.grant_n = dba_pkg::DBA_GRANT_RST;
                end
            end
            dba_pkg::DBA_ST_HELD: begin
                // Only the rising edge of busy reopens arbitration
                if (st_r.busy_sync_n) begin
                    st_nxt.state = dba_pkg::DBA_ST_IDLE;
                end
                // Tell the owner a higher level (prioritized) or any other level waits, never in single-level mode; it may finish at leisure
                unique case (arb_mode)
                    dba_pkg::DBA_MODE_PRI: begin
                        st_nxt.clear_n = (req_act >> st_r.last_lvl) <= 4'h1;
                    end
                    dba_pkg::DBA_MODE_SGL: begin
                        st_nxt.clear_n = 1'b1;
                    end
                    default: begin
                        st_nxt.clear_n = (req_act & ~(4'h1 << st_r.last_lvl)) == 4'h0;
                    end
                endcase
            end
            default: begin
                st_nxt.state = dba_pkg::DBA_ST_IDLE;
                st_nxt.grant_n = dba_pkg::DBA_GRANT_RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_r.req_meta_n <= dba_pkg::DBA_REQ_RST;
            st_r.req_sync_n <= dba_pkg::DBA_REQ_RST;
            st_r.busy_meta_n <= 1'b1;
            st_r.busy_sync_n <= 1'b1;
            st_r.state <= dba_pkg::DBA_ST_IDLE;
            st_r.grant_n <= dba_pkg::DBA_GRANT_RST;
            st_r.clear_n <= 1'b1;
            st_r.last_lvl <= dba_pkg::DBA_LAST_RST;
            st_r.timer <= dba_pkg::DBA_TMR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_grant_n = st_r.grant_n;
    assign bus_clear_n = st_r.clear_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic [3:0] gnt_act;
    logic offer_start;
    assign gnt_act = ~st_r.grant_n;
    // Idle clears the timer, so a zero count marks the first offer cycle
    assign offer_start = (st_r.state == dba_pkg::DBA_ST_OFFER) && (st_r.timer == dba_pkg::DBA_TMR_RST);

    sequence s_offer_taken;
        st_r.state == dba_pkg::DBA_ST_OFFER && !st_r.busy_sync_n ##1 st_r.state == dba_pkg::DBA_ST_HELD;
    endsequence

    sequence s_held_busy;
        st_r.state == dba_pkg::DBA_ST_HELD && !st_r.busy_sync_n;
    endsequence

    chk_single_grant: assert property ($onehot0(gnt_act))
        else $error("More than one grant line active");

    chk_grant_cause: assert property (offer_start |-> (gnt_act & $past(req_act)) != 4'h0)
        else $error("Grant issued on a level without a request");

    chk_pri_order: assert property (offer_start && arb_mode == dba_pkg::DBA_MODE_PRI
        |-> ($past(req_act) & ~((gnt_act << 1) - 4'h1)) == 4'h0)
        else $error("Prioritized grant skipped a higher request");

    chk_rr_rotate: assert property (offer_start && arb_mode == dba_pkg::DBA_MODE_RRS
        && $past(req_act[st_r.last_lvl - 2'h1], 2) == 1'b1 && $past(arb_mode) == dba_pkg::DBA_MODE_RRS
        |-> st_r.last_lvl == $past(st_r.last_lvl) - 2'h1)
        else $error("Round-robin did not favour the next lower level");

    chk_sgl_only: assert property (arb_mode == dba_pkg::DBA_MODE_SGL && $past(arb_mode) == dba_pkg::DBA_MODE_SGL
        && $past(st_r.state) == dba_pkg::DBA_ST_IDLE |-> st_r.grant_n[2:0] == 3'h7)
        else $error("Single-level mode granted below level three");

    chk_no_regrant: assert property (s_held_busy |=> st_r.state != dba_pkg::DBA_ST_OFFER && st_r.grant_n == 4'hf)
        else $error("New grant before busy rose");

    chk_grant_drop: assert property (s_offer_taken |-> bus_grant_n == 4'hf ##1 st_r.state != dba_pkg::DBA_ST_OFFER)
        else $error("Grant not released after busy taken");

    chk_timeout_end: assert property (st_r.state == dba_pkg::DBA_ST_OFFER && st_r.busy_sync_n
        && st_r.timer == TMR_LAST |=> st_r.state == dba_pkg::DBA_ST_IDLE && bus_grant_n == 4'hf)
        else $error("Unanswered grant not withdrawn on time");

    chk_sync_depth: assert property (##2 st_r.req_sync_n == $past(bus_req_n, 2)
        && st_r.busy_sync_n == $past(bus_busy_n, 2))
        else $error("Synchroniser depth is not two stages");

endmodule

// file: dba_req_model.sv
/* Requester boards on the backplane, one per request level.
   Assumes the bench adds requests by a one-cycle pulse on add_req. */
`timescale 1ns/1ps
module dba_req_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] bus_grant_n,
    input wire logic [3:0] add_req,
    input wire logic mute,
    output logic [3:0] bus_req_n,
    output logic bus_busy_n,
    output logic [3:0] chain_out_n,
    output logic served,
    output logic [1:0] served_lvl
);
    logic [3:0] req_r;
    logic [3:0] nxt;
    int hold;
    // A requesting level absorbs its grant, the others pass it on
    assign chain_out_n = bus_grant_n | req_r;
    assign bus_req_n = ~req_r;
    always @(posedge clk_sys) begin
        served <= 1'b0;
        if (!resetn) begin
            req_r <= 4'h0;
            bus_busy_n <= 1'b1;
            hold = 0;
        end else if (hold > 0) begin
            hold = hold - 1;
            // Other boards may still raise requests while the bus is held
            req_r <= req_r | add_req;
            // Released busy returns to the terminator level
            if (hold == 0) bus_busy_n <= 1'b1;
        end else begin
            nxt = req_r | add_req;
            for (int l = 0; l < 4; l++) begin
                // Mute models a board that never answers its grant
                if (!mute && req_r[l] && !bus_grant_n[l]) begin
                    nxt[l] = 1'b0;
                    bus_busy_n <= 1'b0;
                    served <= 1'b1;
                    served_lvl <= 2'(l);
                    hold = 10;
                end
            end
            req_r <= nxt;
        end
    end
endmodule

// file: data_bus_arbitration_tb.sv
/* Self-checking bench for the slot-one arbiter against a scheduling model.
   Assumes the requester model answers grants and holds busy ten cycles. */
`timescale 1ns/1ps
module data_bus_arbitration_tb;
    localparam int TO = 8;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] add_req = 4'h0;
    logic mute = 1'b0;
    dba_pkg::dba_mode_t arb_mode = dba_pkg::DBA_MODE_PRI;
    logic [3:0] bus_req_n;
    logic [3:0] bus_grant_n;
    logic bus_busy_n;
    logic bus_clear_n;
    logic served;
    logic [1:0] served_lvl;
    int err_total = 0;
    int compares = 0;
    int busy_run = 0;

    dba_arbiter #(.TIMEOUT_CYC(TO)) dba_arbiter_inst (.clk_sys(clk_sys), .resetn(resetn), .bus_req_n(bus_req_n),
        .bus_busy_n(bus_busy_n), .arb_mode(arb_mode), .bus_grant_n(bus_grant_n), .bus_clear_n(bus_clear_n));
    dba_req_model dba_req_model_inst (.clk_sys(clk_sys), .resetn(resetn), .bus_grant_n(bus_grant_n),
        .add_req(add_req), .mute(mute), .bus_req_n(bus_req_n), .bus_busy_n(bus_busy_n), .chain_out_n(),
        .served(served), .served_lvl(served_lvl));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        compares++;
        if (exp !== got) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scheduling model
    // ----------------------------------------------------------------
    function automatic int pick(int m, logic [3:0] r, int last);
        int s;
        int n;
        int l;
        if (m == 2) return r[3] ? 3 : -1;
        n = (m == 3 && !r[3]) ? 3 : 4;
        if (m == 0 || (m == 3 && r[3])) s = 3;
        else if (m == 1) s = (last + 3) % 4;
        else s = (last == 3) ? 2 : (last + 2) % 3;
        for (int i = 0; i < n; i++) begin
            l = (s - i + n) % n;
            if (r[l]) return l;
        end
        return -1;
    endfunction

    // Grant may lag busy by the two synchroniser stages and the state register; checked from the fifth busy cycle
    always @(posedge clk_sys) begin
        busy_run <= (resetn && !bus_busy_n) ? busy_run + 1 : 0;
        if (resetn && bus_grant_n !== 4'hf) check("grants low", 4'h1, 4'($countones(~bus_grant_n)));
        if (busy_run > 3) check("grant while busy", 4'hf, bus_grant_n);
    end

    task automatic do_reset(int n);
        resetn <= 1'b0;
        repeat (n) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
    endtask

    task automatic wait_served(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 60 && !ok; i++) begin
            @(posedge clk_sys);
            ok = served;
        end
    endtask

    task automatic start(int m, logic [3:0] mask, logic q);
        do_reset(3);
        arb_mode <= dba_pkg::dba_mode_t'(m);
        mute <= q;
        add_req <= mask;
        @(posedge clk_sys);
        add_req <= 4'h0;
    endtask

    task automatic run_mode(int m, logic [3:0] mask);
        int last;
        int e;
        logic [3:0] pend;
        logic clr;
        bit ok;
        start(m, mask, 1'b0);
        pend = mask;
        last = 0;
        e = pick(m, pend, last);
        while (e >= 0) begin
            wait_served(ok);
            check("served level", 4'(e), ok ? 4'(served_lvl) : 4'hf);
            pend[e] = 1'b0;
            last = e;
            repeat (6) @(posedge clk_sys);
            clr = (m == 2) ? 1'b0 : (m == 0) ? |(pend >> (e + 1)) : |pend;
            check("bus clear", {3'h0, ~clr}, {3'h0, bus_clear_n});
            e = pick(m, pend, last);
        end
        repeat (40) @(posedge clk_sys);
        check("idle grants", 4'hf, bus_grant_n);
    endtask

    initial begin
        int n;
        bit ok;
        void'($urandom(32'h74a236e5));
        do_reset(16);
        check("grant after reset", 4'hf, bus_grant_n);
        check("clear after reset", 4'h1, {3'h0, bus_clear_n});
        for (int m = 0; m < 4; m++) begin
            run_mode(m, 4'hf);
            run_mode(m, 4'($urandom_range(15, 1)));
        end
        // Unanswered grant is withdrawn, then offered again
        start(0, 4'h4, 1'b1);
        for (n = 0; n < 20 && bus_grant_n !== 4'hb; n++) @(posedge clk_sys);
        for (n = 0; n < 40 && bus_grant_n === 4'hb; n++) @(posedge clk_sys);
        check("timeout span", 4'h1, 4'(n >= TO - 1 && n <= TO + 2));
        mute <= 1'b0;
        wait_served(ok);
        check("regrant", 4'h2, ok ? 4'(served_lvl) : 4'hf);
        // A higher request arriving while the bus is held pulls bus clear low
        start(0, 4'h2, 1'b0);
        wait_served(ok);
        check("held level", 4'h1, ok ? 4'(served_lvl) : 4'hf);
        add_req <= 4'h8;
        @(posedge clk_sys);
        add_req <= 4'h0;
        repeat (5) @(posedge clk_sys);
        check("clear on higher", 4'h0, {3'h0, bus_clear_n});
        wait_served(ok);
        check("later level", 4'h3, ok ? 4'(served_lvl) : 4'hf);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        print_verdict();
    end
endmodule
